/* rtl/sbir_defines.svh */
// Purpose: Named constants of the sound buffer register slice.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Header holds definitions only.
`ifndef SBIR_DEFINES_SVH
`define SBIR_DEFINES_SVH

`define SBIR_AW            12
`define SBIR_ADDR_BUF      12'h000
`define SBIR_ADDR_FLAGS    12'h004
`define SBIR_ADDR_ENABLE   12'h008
`define SBIR_ADDR_MODE     12'h00c

`define SBIR_BUF_RST       16'h00ff
`define SBIR_STRB_HALF     4'h3
`define SBIR_RS_BIT        14
`define SBIR_LEN_HI        13
`define SBIR_LEN_LO        8
`define SBIR_PITCH_HI      7
`define SBIR_PITCH_LO6     5
`define SBIR_BUSY_BIT      8
`define SBIR_EMPTY_BIT     1
`define SBIR_DONE_BIT      0
`define SBIR_FLAGS_MASK    32'h00000103
`define SBIR_EN_MASK       32'h00000003

`define SBIR_CLK_HZ        200000000
`define SBIR_SND_HZ        32768
`define SBIR_DUR_UNIT      1024
`define SBIR_ONESHOT_TICKS 8192

`endif

/* rtl/sbir_pkg.sv */
// Purpose: Types shared by the sound buffer register slice and its tone core.
// Assumes: Constants come from sbir_defines.svh.
// Notes:   Mode codes match the output mode field.
package sbir_pkg;

  typedef enum logic [1:0] {
    SBIR_BUZZ    = 2'b00,
    SBIR_ONESHOT = 2'b01,
    SBIR_MELODY  = 2'b10,
    SBIR_RSVD    = 2'b11
  } sbir_mode_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        slverr;
    logic [15:0] buffer;
    logic        empty;
    logic        done;
    logic        busy;
    logic [1:0]  en;
    sbir_mode_t  mode;
    logic        wr_pulse;
    logic        irq;
    logic [15:0] tick_cnt;
  } sbir_regs_t;

  typedef struct packed {
    logic        play;
    logic [15:0] word;
    logic [7:0]  pcnt;
    logic [19:0] dcnt;
    logic        bz;
  } sbir_tone_t;

endpackage : sbir_pkg

/* rtl/sbir_tone.sv */
// Purpose: Tone core: plays the loaded sound register on the buzzer pins.
// Assumes: tick_i is a one-cycle enable at the sound clock rate.
// Notes:   Both pins are low while idle.
`timescale 1ns/1ps
`include "sbir_defines.svh"
module sbir_tone
  import sbir_pkg::*;
#(
  parameter int unsigned DUR_UNIT      = `SBIR_DUR_UNIT,
  parameter int unsigned ONESHOT_TICKS = `SBIR_ONESHOT_TICKS
)(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        tick_i,
  input  wire logic        load_i,
  input  wire logic [15:0] word_i,
  input  wire sbir_mode_t  mode_i,
  input  wire logic        pending_i,
  output logic             seg_end_o,
  output logic             buzzer_out_true_o,
  output logic             buzzer_out_inverted_o
);

  sbir_tone_t st;
  sbir_tone_t next_st;
  logic       melody;
  logic [7:0] pitch_eff;
  logic [5:0] len;
  logic [19:0] limit;
  logic       high;

  always_comb
  begin
    melody    = (mode_i == SBIR_MELODY);
    len       = st.word[`SBIR_LEN_HI:`SBIR_LEN_LO];
    pitch_eff = melody ? st.word[`SBIR_PITCH_HI:0]
                       : {2'b00, st.word[`SBIR_PITCH_LO6:0]};
    limit     = (mode_i == SBIR_ONESHOT) ? 20'(ONESHOT_TICKS)
                                         : 20'((32'(len) + 32'd1) * DUR_UNIT);
    if (mode_i == SBIR_BUZZ || mode_i == SBIR_RSVD)
      seg_end_o = st.play && tick_i && pending_i;
    else
      seg_end_o = st.play && tick_i && (st.dcnt + 20'd1 >= limit);
    high = melody ? (st.pcnt <= (pitch_eff >> 1))
                  : (st.pcnt < {2'b00, len});
    next_st = st;
    if (tick_i && st.play)
    begin
      next_st.dcnt = st.dcnt + 20'd1;
      next_st.pcnt = (st.pcnt >= pitch_eff) ? 8'h00 : st.pcnt + 8'h01;
    end
    if (load_i)
    begin
      next_st.play = 1'b1;
      next_st.word = word_i;
      next_st.pcnt = 8'h00;
      next_st.dcnt = 20'h00000;
    end
    else if (seg_end_o)
      next_st.play = 1'b0;
    // A rest only applies in melody mode; buzzer modes ignore the bit.
    if (melody && next_st.word[`SBIR_RS_BIT])
      next_st.bz = 1'b0;
    else
      next_st.bz = next_st.play && high;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign buzzer_out_true_o     = st.bz;
  assign buzzer_out_inverted_o = st.play && !st.bz;

  a_rest_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.play && mode_i == SBIR_MELODY && st.word[`SBIR_RS_BIT])
      |-> (!buzzer_out_true_o && buzzer_out_inverted_o))
    else $error("rest does not hold the pins at low and high");

  a_pitch_low_six: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.play && mode_i != SBIR_MELODY) |-> (st.pcnt <= {2'b00, st.word[`SBIR_PITCH_LO6:0]}))
    else $error("buzzer pitch counter passed the six-bit pitch");

endmodule : sbir_tone

/* rtl/sbir_regs.sv */
// Purpose: APB register slice of the sound generator: buffer, flags, enables, mode.
// Assumes: Single clock, synchronous active-high reset, APB4 slave with strobes.
// Notes:   Buffer writes count only with both low byte lanes strobed.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sbir_defines.svh"
module sbir_regs
  import sbir_pkg::*;
#(
  parameter int unsigned TICK_DIV      = `SBIR_CLK_HZ / `SBIR_SND_HZ,
  parameter int unsigned DUR_UNIT      = `SBIR_DUR_UNIT,
  parameter int unsigned ONESHOT_TICKS = `SBIR_ONESHOT_TICKS
)(
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [`SBIR_AW-1:0]  paddr_i,
  input  wire logic [31:0]          pwdata_i,
  input  wire logic [3:0]           pstrb_i,
  output logic                      pready_o,
  output logic [31:0]               prdata_o,
  output logic                      pslverr_o,
  output logic                      snd_wr_o,
  output logic [1:0]                snd_mode_o,
  output logic                      irq_o,
  output logic                      buzzer_out_true_o,
  output logic                      buzzer_out_inverted_o
);

  sbir_regs_t st;
  sbir_regs_t next_st;

  logic        access;
  logic        wr_commit;
  logic        wr_buf;
  logic        wr_flags;
  logic        wr_enable;
  logic        wr_mode;
  logic        tick;
  logic        seg_end;
  logic        trig;
  logic        do_load;
  logic [15:0] load_word;
  logic        mapped;

  function automatic logic addr_hit(input logic [`SBIR_AW-1:0] a);
    addr_hit = (a == `SBIR_ADDR_BUF) || (a == `SBIR_ADDR_FLAGS)
            || (a == `SBIR_ADDR_ENABLE) || (a == `SBIR_ADDR_MODE);
  endfunction : addr_hit

  function automatic logic [31:0] flags_word(input logic busy, input logic empty,
                                             input logic done);
    flags_word                  = 32'h00000000;
    flags_word[`SBIR_BUSY_BIT]  = busy;
    flags_word[`SBIR_EMPTY_BIT] = empty;
    flags_word[`SBIR_DONE_BIT]  = done;
  endfunction : flags_word

  always_comb
  begin
    access    = psel_i && penable_i;
    mapped    = addr_hit(paddr_i);
    wr_commit = access && st.ack && pwrite_i && mapped;
    wr_buf    = wr_commit && (paddr_i == `SBIR_ADDR_BUF)
             && ((pstrb_i & `SBIR_STRB_HALF) == `SBIR_STRB_HALF);
    wr_flags  = wr_commit && (paddr_i == `SBIR_ADDR_FLAGS);
    wr_enable = wr_commit && (paddr_i == `SBIR_ADDR_ENABLE);
    wr_mode   = wr_commit && (paddr_i == `SBIR_ADDR_MODE);
    tick      = (st.tick_cnt == 16'(TICK_DIV - 1));
    // A trigger comes when a duration ends (in buzz or reserved mode, at a tick with a word waiting), or at once when idle with a word waiting.
    trig      = seg_end || (!st.busy && !st.empty);
    do_load   = trig && (!st.empty || wr_buf);
    load_word = wr_buf ? pwdata_i[15:0] : st.buffer;

    next_st          = st;
    next_st.wr_pulse = wr_buf;
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;

    if (access && !st.ack)
    begin
      next_st.ack    = 1'b1;
      next_st.slverr = !mapped;
      next_st.rdata  = 32'h00000000;
      if (!pwrite_i)
      begin
        unique case (paddr_i)
          `SBIR_ADDR_BUF:    next_st.rdata = {16'h0000, st.buffer};
          `SBIR_ADDR_FLAGS:  next_st.rdata = flags_word(st.busy, st.empty, st.done);
          `SBIR_ADDR_ENABLE: next_st.rdata = {30'h00000000, st.en};
          `SBIR_ADDR_MODE:   next_st.rdata = {30'h00000000, st.mode};
          default:           next_st.rdata = 32'h00000000;
        endcase
      end
    end
    else
    begin
      next_st.ack    = 1'b0;
      next_st.slverr = 1'b0;
    end

    if (wr_buf)
    begin
      next_st.buffer = pwdata_i[15:0];
      next_st.empty  = 1'b0;
      next_st.done   = 1'b0;
    end
    if (wr_flags && pwdata_i[`SBIR_DONE_BIT])
      next_st.done = 1'b0;
    if (wr_enable)
      next_st.en = pwdata_i[`SBIR_EMPTY_BIT:`SBIR_DONE_BIT];
    if (wr_mode)
      next_st.mode = sbir_mode_t'(pwdata_i[1:0]);

    // Hardware events come last so that a set beats a same-cycle clear.
    if (do_load)
    begin
      next_st.empty = 1'b1;
      next_st.busy  = 1'b1;
    end
    else if (trig)
    begin
      next_st.done = 1'b1;
      next_st.busy = 1'b0;
    end
    next_st.irq = |({next_st.empty, next_st.done} & next_st.en);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st        <= '0;
      st.buffer <= `SBIR_BUF_RST;
      st.empty  <= 1'b1;
    end
    else
      st <= next_st;
  end

  sbir_tone #(
    .DUR_UNIT      (DUR_UNIT),
    .ONESHOT_TICKS (ONESHOT_TICKS)
  ) u_tone (
    .clk_i                 (clk_i),
    .sys_rst_i             (sys_rst_i),
    .tick_i                (tick),
    .load_i                (do_load),
    .word_i                (load_word),
    .mode_i                (st.mode),
    .pending_i             (!st.empty),
    .seg_end_o             (seg_end),
    .buzzer_out_true_o     (buzzer_out_true_o),
    .buzzer_out_inverted_o (buzzer_out_inverted_o)
  );

  assign pready_o   = st.ack;
  assign prdata_o   = st.rdata;
  assign pslverr_o  = st.slverr;
  assign snd_wr_o   = st.wr_pulse;
  assign snd_mode_o = st.mode;
  assign irq_o      = st.irq;

  sequence s_buf_setup;
    psel_i && !penable_i && pwrite_i && (paddr_i == `SBIR_ADDR_BUF);
  endsequence

  sequence s_buf_full_write;
    s_buf_setup ##1 (access && !st.ack && pstrb_i[1:0] == 2'b11) ##1 (access && st.ack);
  endsequence

  sequence s_buf_byte_write;
    s_buf_setup ##1 (access && !st.ack && pstrb_i[1:0] != 2'b11) ##1 (access && st.ack);
  endsequence

  a_load_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_buf_full_write |=> (snd_wr_o ##1 !snd_wr_o))
    else $error("full buffer write gave no single-cycle load pulse");

  a_byte_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_buf_byte_write |=> ($stable(st.buffer) && !snd_wr_o))
    else $error("byte write changed the sound buffer");

  a_empty_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_buf && !trig) |=> !st.empty)
    else $error("buffer write did not clear the empty flag");

  a_load_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_load |=> (st.empty && st.busy && $changed(st.tick_cnt)))
    else $error("sound register load did not set empty and busy");

  a_stop_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (trig && !do_load) |=> (st.done && !st.busy))
    else $error("stop did not set complete and clear busy");

  a_done_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.done && !wr_buf && !(wr_flags && pwdata_i[`SBIR_DONE_BIT])) |=> st.done)
    else $error("complete flag dropped without a clearing write");

  a_done_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_flags && pwdata_i[`SBIR_DONE_BIT] && !trig) |=> !st.done)
    else $error("writing one did not clear the complete flag");

  a_irq_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o == |({st.empty, st.done} & st.en))
    else $error("interrupt request disagrees with flags and enables");

  a_reset_vals: assert property (@(posedge clk_i)
    sys_rst_i |=> (st.empty && !st.done && !st.busy && st.en == 2'b00 && !irq_o))
    else $error("flag or enable reset value wrong");

  a_apb_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (access && !st.ack) |=> (pready_o ##1 !pready_o))
    else $error("access phase not answered on its second cycle");

  a_busy_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!st.busy && !do_load) [*2] |-> !buzzer_out_true_o)
    else $error("buzzer sounds while idle");

  // Read answers are checked at the edge that carries pready, while the request still stands.
  sequence s_flags_read;
    psel_i && pready_o && !pwrite_i && (paddr_i == `SBIR_ADDR_FLAGS);
  endsequence

  sequence s_enable_read;
    psel_i && pready_o && !pwrite_i && (paddr_i == `SBIR_ADDR_ENABLE);
  endsequence

  // Status bits move only through their own causes, so no software write can fake an event.
  a_empty_ro: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_flags && !do_load) |=> $stable(st.empty))
    else $error("flag write changed the empty flag");

  a_busy_ro: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_commit && !trig) |=> $stable(st.busy))
    else $error("register write changed the busy bit");

  a_buffer_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_buf |=> $stable(st.buffer))
    else $error("sound buffer changed without a full write");

  a_enable_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_enable |=> $stable(st.en))
    else $error("enables changed without an enable write");

  a_mode_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_mode |=> $stable(snd_mode_o))
    else $error("mode changed without a mode write");

  a_pulse_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    snd_wr_o |-> $past(wr_buf))
    else $error("load pulse without an accepted buffer write");

  a_done_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.done) |-> $past(trig))
    else $error("complete flag set without a trigger");

  a_empty_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.empty) |-> $past(do_load))
    else $error("empty flag set without a load");

  a_busy_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.busy) |-> $past(do_load))
    else $error("busy set without a load");

  a_busy_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(st.busy) |-> st.done)
    else $error("busy cleared without the complete flag");

  a_flags_rsvd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_flags_read |-> ((prdata_o & ~`SBIR_FLAGS_MASK) == 32'h00000000))
    else $error("reserved flag bits read nonzero");

  a_enable_rsvd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_enable_read |-> ((prdata_o & ~`SBIR_EN_MASK) == 32'h00000000))
    else $error("reserved enable bits read nonzero");

  a_irq_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.en == 2'b00) |-> !irq_o)
    else $error("interrupt request with both enables off");

endmodule : sbir_regs

/* sim/sbir_buzzer_model.sv */
// Purpose: Piezo load model on the complementary buzzer pins.
// Assumes: Pins are push-pull; the element only sounds when the pins differ.
// Notes:   Counts rising edges of the true pin while the inverted pin is low.
`timescale 1ns/1ps
module sbir_buzzer_model (
  input  wire logic        clk_i,
  input  wire logic        true_i,
  input  wire logic        inv_i,
  output logic [15:0]      edges_o
);
  logic last;
  initial edges_o = 16'h0000;
  initial last = 1'b0;
  always @(posedge clk_i)
  begin
    if (true_i === 1'b1 && last !== 1'b1 && inv_i === 1'b0)
      edges_o <= edges_o + 16'h0001;
    last <= true_i;
  end
endmodule : sbir_buzzer_model

/* sim/sound_buffer_irq_regs_tb.sv */
// Purpose: Self-checking bench of the sound buffer register slice.
// Assumes: Short tone counts so that each sound lasts a few dozen cycles.
// Notes:   Read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
`include "sbir_defines.svh"
module sound_buffer_irq_regs_tb;
  import sbir_pkg::*;
  logic        clk_i;
  logic        sys_rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        snd_wr_o;
  logic [1:0]  snd_mode_o;
  logic        irq_o;
  logic        bz_t;
  logic        bz_n;
  logic [15:0] edges;
  logic [15:0] e0;
  logic [15:0] d0;
  logic [31:0] rd;
  logic [31:0] v;
  logic [15:0] words[3];
  logic [32:0] notes[$];
  int          mismatches;
  int          tests_run;
  int          wr_seen;
  int          wr_exp;
  int          seed;
  int          i;

  sbir_regs #(.TICK_DIV(4), .DUR_UNIT(2), .ONESHOT_TICKS(4)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .snd_wr_o(snd_wr_o),
    .snd_mode_o(snd_mode_o), .irq_o(irq_o), .buzzer_out_true_o(bz_t), .buzzer_out_inverted_o(bz_n));

  sbir_buzzer_model piezo_u (.clk_i(clk_i), .true_i(bz_t), .inv_i(bz_n), .edges_o(edges));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task results;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 40);
    if (pready_o !== 1'b1)
    begin
      mismatches++;
      results();
    end
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [32:0] exp);
    notes.push_back(exp);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask : rdchk

  task wait_busy(input logic want);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `SBIR_ADDR_FLAGS, 32'h0000_0000, 4'hf);
      n++;
    end
    while (rd[8] !== want && n < 100);
    if (rd[8] !== want)
    begin
      mismatches++;
      results();
    end
  endtask : wait_busy

  // Each queued read is compared when its data stands with pready.
  always @(negedge clk_i)
  begin
    if (snd_wr_o === 1'b1)
      wr_seen++;
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && notes.size() > 0)
      chk({pslverr_o, prdata_o}, notes.pop_front());
  end

  initial
  begin
    seed = 32'hd1eb8493;
    mismatches = 0;
    tests_run = 0;
    wr_seen = 0;
    wr_exp = 0;
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'h0;
    words[0] = 16'h0101;
    words[1] = 16'h01c1;
    words[2] = 16'h4101;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0002);
    rdchk(`SBIR_ADDR_ENABLE, 33'h0_0000_0000);
    rdchk(`SBIR_ADDR_BUF, 33'h0_0000_00ff);
    rdchk(12'h010, 33'h1_0000_0000);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, `SBIR_ADDR_MODE, i, 4'hf);
      rdchk(`SBIR_ADDR_MODE, i);
      chk({31'h0, snd_mode_o}, i);
    end
    v = $random(seed);
    apb(1'b1, `SBIR_ADDR_ENABLE, v, 4'hf);
    rdchk(`SBIR_ADDR_ENABLE, {31'h0, v[1:0]});
    apb(1'b1, `SBIR_ADDR_FLAGS, 32'hffff_fefc, 4'hf);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0002);
    apb(1'b1, `SBIR_ADDR_BUF, 32'h0000_1234, 4'h1);
    rdchk(`SBIR_ADDR_BUF, 33'h0_0000_00ff);
    apb(1'b1, `SBIR_ADDR_MODE, 32'h2, 4'hf);
    apb(1'b1, `SBIR_ADDR_ENABLE, 32'h3, 4'hf);
    apb(1'b1, `SBIR_ADDR_BUF, 32'h0000_4310, 4'h3);
    wr_exp++;
    wait_busy(1'b1);
    chk({31'h0, bz_t, bz_n}, 33'h1);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0102);
    rdchk(`SBIR_ADDR_BUF, 33'h0_0000_4310);
    wait_busy(1'b0);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0003);
    chk({32'h0, irq_o}, 33'h1);
    apb(1'b1, `SBIR_ADDR_FLAGS, 32'hffff_fffe, 4'hf);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0003);
    apb(1'b1, `SBIR_ADDR_ENABLE, 32'h0, 4'hf);
    repeat (2) @(negedge clk_i);
    chk({32'h0, irq_o}, 33'h0);
    e0 = edges;
    apb(1'b1, `SBIR_ADDR_BUF, 32'h0000_0301, 4'h3);
    wr_exp++;
    wait_busy(1'b1);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0102);
    wait_busy(1'b0);
    chk({32'h0, edges != e0}, 33'h1);
    apb(1'b1, `SBIR_ADDR_FLAGS, 32'h1, 4'hf);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0002);
    apb(1'b1, `SBIR_ADDR_ENABLE, 32'h1, 4'hf);
    repeat (2) @(negedge clk_i);
    chk({32'h0, irq_o}, 33'h0);
    apb(1'b1, `SBIR_ADDR_ENABLE, 32'h2, 4'hf);
    repeat (2) @(negedge clk_i);
    chk({32'h0, irq_o}, 33'h1);
    apb(1'b1, `SBIR_ADDR_MODE, 32'h1, 4'hf);
    for (i = 0; i < 3; i++)
    begin
      e0 = edges;
      apb(1'b1, `SBIR_ADDR_BUF, {16'h0, words[i]}, 4'h3);
      wr_exp++;
      wait_busy(1'b1);
      wait_busy(1'b0);
      if (i == 0)
        d0 = edges - e0;
      chk({17'h0, edges - e0}, {17'h0, d0});
    end
    chk({32'h0, d0 != 16'h0}, 33'h1);
    apb(1'b1, `SBIR_ADDR_MODE, 32'h0, 4'hf);
    apb(1'b1, `SBIR_ADDR_BUF, 32'h0000_0101, 4'h3);
    wr_exp++;
    wait_busy(1'b1);
    e0 = edges;
    repeat (40) @(posedge clk_i);
    chk({32'h0, edges != e0}, 33'h1);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0102);
    apb(1'b1, `SBIR_ADDR_BUF, 32'h0000_0103, 4'h3);
    wr_exp++;
    repeat (12) @(posedge clk_i);
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0102);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(`SBIR_ADDR_FLAGS, 33'h0_0000_0002);
    rdchk(`SBIR_ADDR_ENABLE, 33'h0_0000_0000);
    rdchk(`SBIR_ADDR_BUF, 33'h0_0000_00ff);
    chk({28'h0, snd_mode_o, irq_o, bz_t, bz_n}, 33'h0);
    chk(wr_seen, wr_exp);
    results();
  end
endmodule : sound_buffer_irq_regs_tb
